//--- mviu_pkg.sv
package mviu_pkg;

    // Source index order is also priority order, index 0 highest
    localparam int NSRC = 12;
    localparam int SRC_EXT = 0;
    localparam int SRC_TOUCH = 1;
    localparam int SRC_TB0 = 2;
    localparam int SRC_CTM_P = 3;
    localparam int SRC_CTM_A = 4;
    localparam int SRC_PTM_P = 5;
    localparam int SRC_PTM_A = 6;
    localparam int SRC_TB1 = 7;
    localparam int SRC_TWO_WIRE = 8;
    localparam int SRC_EEPROM = 9;
    localparam int SRC_SERIAL = 10;
    localparam int SRC_LOW_VOLT = 11;

    localparam logic [7:0] VEC_BASE = 8'h04;
    localparam logic [7:0] VEC_STEP = 8'h04;

    localparam int PC_W = 13;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h04;
    localparam logic [7:0] OFS_CTRL_SECOND = 8'h08;
    localparam logic [7:0] OFS_CTRL_THIRD = 8'h0c;
    localparam logic [7:0] OFS_EDGE_SEL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field positions
    localparam int CZ_MASTER_EN = 0;
    localparam int CZ_EN_LO = 1;
    localparam int CZ_FLAG_LO = 4;
    localparam int GRP_EN_LO = 0;
    localparam int GRP_FLAG_LO = 4;
    localparam int CT_EN = 0;
    localparam int CT_FLAG = 4;
    localparam int EDGE_LO = 0;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] EDGE_RESET = 2'b00;

    localparam logic [1:0] EDGE_OFF = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : mviu_pkg

//--- mviu_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Second register: four flags high, four enables low
// - Third register bit 4 is low-voltage flag
// - Third register bit 0 is low-voltage enable
// - Third register unused bits read zero
// - Source event sets its flag regardless of enable
// - Flag vectors only when its enable is set
// - Master enable clear blocks every interrupt
// - Taking pushes next PC, loads vector
// - Return instruction pops saved PC and resumes
// - Every source owns a distinct vector
// - Entry clears master enable automatically
// - Blocked requests still set and hold flags
// - Full stack blocks acknowledgement until pop
// - Fixed priority, external pin highest, low-voltage lowest
// - Newly set flag wakes from sleep or idle
// - Entry clears the serviced source's flag
// - External pin 04h, touch 08h
// - Time base zero vectors to 0ch
// - Compact timer 10h/14h, periodic A 1ch
// - Time base one 20h, two-wire 24h, eeprom 28h
// - Low-voltage vectors to 30h, lowest priority
// - Edge select: off, rise, fall, both
// - EEPROM flag set when write cycle completes
module mviu_top
    import mviu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [mviu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mviu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External pin level, then peripheral events as one-cycle pulses
    input wire logic ext_pin,
    input wire logic ev_touch,
    input wire logic ev_tb0,
    input wire logic ev_ctm_p,
    input wire logic ev_ctm_a,
    input wire logic ev_ptm_p,
    input wire logic ev_ptm_a,
    input wire logic ev_tb1,
    input wire logic ev_two_wire,
    input wire logic ev_eeprom_done,
    input wire logic ev_serial,
    input wire logic ev_low_volt,
    // CPU sequencer
    input wire logic instr_boundary,
    input wire logic [mviu_pkg::PC_W-1:0] next_pc,
    input wire logic stack_full,
    input wire logic return_from_irq_instr,
    output logic irq_take,
    output logic [7:0] irq_vector,
    output logic stack_push,
    output logic [mviu_pkg::PC_W-1:0] stack_push_pc,
    output logic stack_pop,
    output logic wake
);
    import mviu_pkg::*;

    // Lowest set index wins, which is the fixed priority order
    function automatic logic [3:0] prio_idx(input logic [NSRC-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : prio_idx

    // One vector step per priority rank keeps every vector distinct
    function automatic logic [7:0] vec_of(input logic [3:0] idx);
        return 8'(VEC_BASE + VEC_STEP * {4'h0, idx});
    endfunction : vec_of

    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] en_q;
    logic master_en_q;
    logic [1:0] edge_sel_q;
    logic ext_prev_q;

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;

    logic irq_take_q;
    logic stack_push_q;
    logic stack_pop_q;
    logic wake_q;
    logic [7:0] irq_vector_q;
    logic [PC_W-1:0] push_pc_q;

    logic [NSRC-1:0] event_vec;
    logic [NSRC-1:0] pending;
    logic take;
    logic [3:0] take_idx;
    logic [NSRC-1:0] take_clr;
    logic wr_fire;
    logic ext_edge;
    logic [NSRC-1:0] sw_mask;
    logic [NSRC-1:0] sw_flag;
    logic [NSRC-1:0] sw_en;
    logic sw_master;
    logic sw_master_val;
    logic sw_edge;

    // Pin is taken as synchronous to mclk; no synchroniser is fitted
    always_comb begin
        ext_edge = 1'b0;
        case (edge_sel_q)
            EDGE_OFF: ext_edge = 1'b0;
            EDGE_RISE: ext_edge = ext_pin & ~ext_prev_q;
            EDGE_FALL: ext_edge = ~ext_pin & ext_prev_q;
            EDGE_BOTH: ext_edge = ext_pin ^ ext_prev_q;
            default: ext_edge = 1'b0;
        endcase
    end

    assign event_vec = {ev_low_volt, ev_serial, ev_eeprom_done, ev_two_wire, ev_tb1,
                        ev_ptm_a, ev_ptm_p, ev_ctm_a, ev_ctm_p, ev_tb0, ev_touch,
                        ext_edge};

    // Interrupt selection
    assign pending = flag_q & en_q;
    assign take = instr_boundary & master_en_q
                  & ~stack_full & (|pending);
    assign take_idx = prio_idx(pending);
    assign take_clr = take ? (NSRC'(1) << take_idx) : '0;

    // Software write decode
    // Applied once, when both halves are held and before the response
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;

    always_comb begin
        sw_mask = '0;
        sw_flag = '0;
        sw_en = '0;
        sw_master = 1'b0;
        sw_master_val = 1'b0;
        sw_edge = 1'b0;
        if (wr_fire && wlane_q) begin
            case (awaddr_q)
                OFS_CTRL_ZERO: begin
                    sw_mask[2:0] = 3'b111;
                    sw_flag[2:0] = wdata_q[CZ_FLAG_LO +: 3];
                    sw_en[2:0] = wdata_q[CZ_EN_LO +: 3];
                    sw_master = 1'b1;
                    sw_master_val = wdata_q[CZ_MASTER_EN];
                end
                OFS_CTRL_ONE: begin
                    sw_mask[6:3] = 4'hf;
                    sw_flag[6:3] = wdata_q[GRP_FLAG_LO +: 4];
                    sw_en[6:3] = wdata_q[GRP_EN_LO +: 4];
                end
                OFS_CTRL_SECOND: begin
                    sw_mask[10:7] = 4'hf;
                    sw_flag[10:7] = wdata_q[GRP_FLAG_LO +: 4];
                    sw_en[10:7] = wdata_q[GRP_EN_LO +: 4];
                end
                OFS_CTRL_THIRD: begin
                    sw_mask[SRC_LOW_VOLT] = 1'b1;
                    sw_flag[SRC_LOW_VOLT] = wdata_q[CT_FLAG];
                    sw_en[SRC_LOW_VOLT] = wdata_q[CT_EN];
                end
                OFS_EDGE_SEL: sw_edge = 1'b1;
                default: sw_mask = '0;
            endcase
        end
    end

    // Flags: hardware set beats both software clear and entry clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= (((flag_q & ~sw_mask) | (sw_flag & sw_mask)) & ~take_clr)
                      | event_vec;
        end
    end

    // Enables change only by software, never by entry
    always_ff @(posedge mclk) begin
        if (rst) begin
            en_q <= '0;
        end else begin
            en_q <= (en_q & ~sw_mask) | (sw_en & sw_mask);
        end
    end

    // Entry clear wins over a same-cycle software set
    always_ff @(posedge mclk) begin
        if (rst) begin
            master_en_q <= 1'b0;
        end else if (take) begin
            master_en_q <= 1'b0;
        end else if (sw_master) begin
            master_en_q <= sw_master_val;
        end
    end

    // Pin level is tracked always, so a new edge select sees no stale level
    // Reset level matches the idle pin, so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            edge_sel_q <= EDGE_RESET;
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_pin;
            if (sw_edge) begin
                edge_sel_q <= wdata_q[EDGE_LO +: 2];
            end
        end
    end

    // CPU side
    // next_pc is sampled in the take cycle, so the return resumes after it
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_take_q <= 1'b0;
            stack_push_q <= 1'b0;
            irq_vector_q <= '0;
            push_pc_q <= '0;
        end else begin
            irq_take_q <= take;
            stack_push_q <= take;
            if (take) begin
                irq_vector_q <= vec_of(take_idx);
                push_pc_q <= next_pc;
            end
        end
    end

    // Stack depth belongs to the core; this block only signals the pop
    always_ff @(posedge mclk) begin
        if (rst) begin
            stack_pop_q <= 1'b0;
        end else begin
            stack_pop_q <= return_from_irq_instr;
        end
    end

    // Only a flag going from clear to set wakes; pre-set flags do not
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= |(event_vec & ~flag_q);
        end
    end

    // AXI4-Lite write channel
    // Address and data may come in either order; each is held until the response
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
            wdata_q <= '0;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (bvalid_q && s_axi_bready) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    // Shared by the write and the read response
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL_ZERO) || (a == OFS_CTRL_ONE) || (a == OFS_CTRL_SECOND)
            || (a == OFS_CTRL_THIRD) || (a == OFS_EDGE_SEL) || (a == OFS_STATUS);
    endfunction : mapped

    // Status is read-only: a write to it is refused and changes nothing
    always_ff @(posedge mclk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= (mapped(awaddr_q) && awaddr_q != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // AXI4-Lite read channel
    // Data is captured at the address handshake and held until taken
    always_ff @(posedge mclk) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_CTRL_ZERO: rdata_q <= {24'h0, 1'b0, flag_q[2:0], en_q[2:0], master_en_q};
                OFS_CTRL_ONE: rdata_q <= {24'h0, flag_q[6:3], en_q[6:3]};
                OFS_CTRL_SECOND: rdata_q <= {24'h0, flag_q[10:7], en_q[10:7]};
                OFS_CTRL_THIRD: rdata_q <= {24'h0, 3'b000, flag_q[SRC_LOW_VOLT], 3'b000,
                                            en_q[SRC_LOW_VOLT]};
                OFS_EDGE_SEL: rdata_q <= {30'h0, edge_sel_q};
                OFS_STATUS: rdata_q <= {23'h0, stack_full, irq_vector_q};
                default: rdata_q <= 32'h0;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // Every output comes straight from a flip-flop
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq_take = irq_take_q;
    assign irq_vector = irq_vector_q;
    assign stack_push = stack_push_q;
    assign stack_push_pc = push_pc_q;
    assign stack_pop = stack_pop_q;
    assign wake = wake_q;

endmodule : mviu_top

//--- mviu_chk.sv
`timescale 1ns/100ps
module mviu_chk
    import mviu_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic instr_boundary,
    input wire logic [mviu_pkg::PC_W-1:0] next_pc,
    input wire logic stack_full,
    input wire logic return_from_irq_instr,
    input wire logic irq_take,
    input wire logic [7:0] irq_vector,
    input wire logic stack_push,
    input wire logic [mviu_pkg::PC_W-1:0] stack_push_pc,
    input wire logic stack_pop
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    take_gate_a:
    assert property (irq_take |-> $past(instr_boundary) && !$past(stack_full))
        else $error("take outside a boundary or with a full stack");
    push_pair_a:
    assert property (stack_push == irq_take)
        else $error("push not paired with take");
    no_nest_a:
    assert property (irq_take |=> !irq_take [*2])
        else $error("second take without a fresh master enable");
    pc_saved_a:
    assert property (irq_take |-> stack_push_pc == $past(next_pc))
        else $error("pushed pc is not the next pc");
    vec_range_a:
    assert property (irq_take |-> irq_vector inside {[8'h04:8'h30]} && irq_vector[1:0] == 2'h0)
        else $error("vector outside the table");
    vec_hold_a:
    assert property (!irq_take && !$past(rst) |-> $stable(irq_vector))
        else $error("vector moved without a take");
    pop_ret_a:
    assert property (return_from_irq_instr |=> stack_pop)
        else $error("return did not pop");
    pop_cause_a:
    assert property (stack_pop |-> $past(return_from_irq_instr))
        else $error("pop without a return");
endmodule : mviu_chk

//--- mviu_cpu_model.sv
`timescale 1ns/100ps
module mviu_cpu_model
    import mviu_pkg::*;
#(
    parameter int DEPTH = 2
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    input wire logic ret_req,
    input wire logic stack_push,
    input wire logic stack_pop,
    output logic instr_boundary,
    output logic [mviu_pkg::PC_W-1:0] next_pc,
    output logic stack_full,
    output logic return_from_irq_instr
);
    int depth_q;
    logic [1:0] phase_q;
    // Slow core: a boundary only every fourth cycle
    assign instr_boundary = !slow || phase_q == 2'h0;
    assign stack_full = depth_q >= DEPTH;
    always_ff @(posedge mclk) begin
        if (rst) begin
            depth_q <= 0;
            phase_q <= 2'h0;
            next_pc <= '0;
        end else begin
            depth_q <= depth_q + int'(stack_push) - int'(stack_pop);
            phase_q <= phase_q + 2'h1;
            next_pc <= next_pc + PC_W'(instr_boundary);
        end
    end
    // Returns only from inside a routine, as software must
    always_ff @(posedge mclk) begin
        return_from_irq_instr <= !rst && ret_req && depth_q != 0;
    end
endmodule : mviu_cpu_model

//--- mcu_vectored_interrupt_unit_bench.sv
`timescale 1ns/100ps
module mcu_vectored_interrupt_unit_bench;
    import mviu_pkg::*;
    logic mclk = 1'h0, rst = 1'h1, slow = 1'h0, ret_req = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_vector, r;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ext_pin = 1'h0, ev_touch = 1'h0, ev_tb0 = 1'h0, ev_ctm_p = 1'h0, ev_ctm_a = 1'h0;
    logic ev_ptm_p = 1'h0, ev_ptm_a = 1'h0, ev_tb1 = 1'h0, ev_two_wire = 1'h0;
    logic ev_eeprom_done = 1'h0, ev_serial = 1'h0, ev_low_volt = 1'h0;
    logic instr_boundary, stack_full, return_from_irq_instr, irq_take, stack_push, stack_pop;
    logic wake;
    logic [PC_W-1:0] next_pc, stack_push_pc;
    logic [33:0] q_rd[$];
    logic [1:0] q_wr[$];
    logic [7:0] q_vec[$];
    logic q_wake[$];
    int n_mismatch = 0;
    int samples_checked = 0;

    always #4 mclk = ~mclk;
    mviu_top mviu_top_inst (.*);
    mviu_cpu_model #(.DEPTH(2)) mviu_cpu_model_inst (.*);

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        q_wr.push_back(rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            aw_ok = aw_ok || s_axi_awready === 1'h1;
            w_ok = w_ok || s_axi_wready === 1'h1;
            if (aw_ok) s_axi_awvalid <= 1'h0;
            if (w_ok) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1) @(posedge mclk);
        s_axi_bready <= 1'h0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        q_rd.push_back({rs, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge mclk);
        s_axi_rready <= 1'h0;
        @(posedge mclk);
    endtask : rd

    task automatic pulse(input logic [11:0] m, input logic w);
        if (w) q_wake.push_back(1'h1);
        {ev_low_volt, ev_serial, ev_eeprom_done, ev_two_wire, ev_tb1, ev_ptm_a, ev_ptm_p,
            ev_ctm_a, ev_ctm_p, ev_tb0, ev_touch} <= m[11:1];
        @(posedge mclk);
        {ev_low_volt, ev_serial, ev_eeprom_done, ev_two_wire, ev_tb1, ev_ptm_a, ev_ptm_p,
            ev_ctm_a, ev_ctm_p, ev_tb0, ev_touch} <= 11'h0;
    endtask : pulse

    task automatic ret();
        ret_req <= 1'h1;
        @(posedge mclk);
        ret_req <= 1'h0;
        repeat (3) @(posedge mclk);
    endtask : ret

    // An unexpected take meets an unknown and so fails
    always @(posedge mclk) begin
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
            chk(34'(s_axi_bresp), 34'(q_wr.pop_front()));
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
            chk({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
        if (irq_take === 1'h1)
            chk(34'(irq_vector), q_vec.size() != 0 ? 34'(q_vec.pop_front()) : 'x);
        if (wake === 1'h1)
            chk(34'(wake), q_wake.size() != 0 ? 34'(q_wake.pop_front()) : 'x);
    end

    initial begin
        repeat (8000) @(posedge mclk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        r = 8'($urandom(32'hf956fc97));
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rd(OFS_CTRL_SECOND, 8'h00, RESP_OKAY);
        rd(OFS_CTRL_THIRD, 8'h00, RESP_OKAY);
        r = 8'($urandom());
        wr(OFS_CTRL_SECOND, r, RESP_OKAY);
        rd(OFS_CTRL_SECOND, r, RESP_OKAY);
        wr(OFS_CTRL_THIRD, ~r, RESP_OKAY);
        rd(OFS_CTRL_THIRD, ~r & 8'h11, RESP_OKAY);
        wr(OFS_STATUS, r, RESP_SLVERR);
        rd(8'h40, 8'h00, RESP_SLVERR);
        wr(OFS_CTRL_SECOND, 8'h00, RESP_OKAY);
        wr(OFS_CTRL_THIRD, 8'h00, RESP_OKAY);
        $display("register test done");
        pulse(12'hf80, 1'h1);
        rd(OFS_CTRL_SECOND, 8'hf0, RESP_OKAY);
        rd(OFS_CTRL_THIRD, 8'h10, RESP_OKAY);
        pulse(12'hf80, 1'h0);
        wr(OFS_CTRL_SECOND, 8'hff, RESP_OKAY);
        wr(OFS_CTRL_THIRD, 8'h11, RESP_OKAY);
        repeat (10) @(posedge mclk);
        // Two takes fill the stack; later ones wait for a return
        for (int i = 0; i < 5; i++) begin
            slow <= 1'($urandom());
            if (i < 2) q_vec.push_back(8'(32'h20 + 4 * i));
            wr(OFS_CTRL_ZERO, 8'h01, RESP_OKAY);
            if (i >= 2) begin
                repeat (20) @(posedge mclk);
                q_vec.push_back(8'(32'h20 + 4 * i));
                ret();
            end
            while (q_vec.size() != 0) @(posedge mclk);
        end
        rd(OFS_CTRL_SECOND, 8'h0f, RESP_OKAY);
        rd(OFS_CTRL_THIRD, 8'h01, RESP_OKAY);
        ret();
        ret();
        $display("priority and stack test done");
        for (int m = 0; m < 4; m++) begin
            wr(OFS_EDGE_SEL, 8'(m), RESP_OKAY);
            wr(OFS_CTRL_ZERO, 8'h00, RESP_OKAY);
            if (m[0]) q_wake.push_back(1'h1);
            ext_pin <= 1'h1;
            @(posedge mclk);
            rd(OFS_CTRL_ZERO, m[0] ? 8'h10 : 8'h00, RESP_OKAY);
            wr(OFS_CTRL_ZERO, 8'h00, RESP_OKAY);
            if (m[1]) q_wake.push_back(1'h1);
            ext_pin <= 1'h0;
            @(posedge mclk);
            rd(OFS_CTRL_ZERO, m[1] ? 8'h10 : 8'h00, RESP_OKAY);
        end
        $display("edge test done");
        wr(OFS_CTRL_ZERO, 8'h00, RESP_OKAY);
        wr(OFS_CTRL_SECOND, 8'h00, RESP_OKAY);
        wr(OFS_CTRL_THIRD, 8'h00, RESP_OKAY);
        wr(OFS_CTRL_ONE, 8'h0f, RESP_OKAY);
        ext_pin <= 1'h1;
        pulse(12'h07e, 1'h1);
        for (int i = 0; i < 7; i++) begin
            q_vec.push_back(8'(4 + 4 * i));
            wr(OFS_CTRL_ZERO, 8'h0f | ((8'h70 << i) & 8'h70), RESP_OKAY);
            while (q_vec.size() != 0) @(posedge mclk);
            ret();
        end
        $display("vector test done");
        chk(34'(q_wake.size()), 34'(0));
        end_sim();
    end
endmodule : mcu_vectored_interrupt_unit_bench

bind mviu_top mviu_chk mviu_chk_inst (.*);
